// ==== sim/enc_link_monitor.sv ====
module enc_link_monitor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ssi_clk,
  input wire logic ssi_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************
  // link history seen from the core clock
  // ************************************
  logic        clk_q_r;
  logic        dat_q_r;
  logic [4:0]  rcnt_r;   // rises seen in this frame
  logic [7:0]  hcnt_r;   // cycles since last clock edge
  logic [11:0] qcnt_r;   // cycles since last rise
  wire         rise = ssi_clk & ~clk_q_r;
  wire         fall = clk_q_r & ~ssi_clk;

  // cycle counters start saturated and the rise count at its idle 5'h18, so a frame right after reset is not a short gap
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_q_r <= 1'b1;
      dat_q_r <= 1'b1;
      rcnt_r  <= 5'h18;
      hcnt_r  <= 8'hFF;
      qcnt_r  <= 12'hFFF;
    end else begin
      clk_q_r <= ssi_clk;
      dat_q_r <= ssi_data;
      rcnt_r  <= (fall && rcnt_r == 5'h18) ? 5'h00 : rcnt_r + {4'h0, rise};
      hcnt_r  <= (rise || fall) ? 8'h00 : hcnt_r + {7'h00, hcnt_r != 8'hFF};
      qcnt_r  <= rise ? 12'h000 : qcnt_r + {11'h000, qcnt_r != 12'hFFF};
    end
  end

  // ************************************
  // properties
  // ************************************
  default clocking mon_cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // the bit shown before a rise is the one the host samples there
  a_half_period: assert property ((rise || fall) |-> hcnt_r >= 8'h0F)
    else $error("serial clock phase too short");
  a_rise_count: assert property (rise |-> rcnt_r <= 5'h17)
    else $error("too many rises in one frame");
  a_start_bit: assert property (rise && rcnt_r == 5'h00 |-> dat_q_r)
    else $error("start bit not one");
  a_first_rise: assert property (fall && rcnt_r == 5'h18 |-> ##[16:100] rise)
    else $error("frame start without rising edge");
  a_data_stable: assert property (
    rcnt_r inside {[5'h01:5'h17]} && !rise |-> ssi_data == dat_q_r)
    else $error("data changed away from a rising edge");
  a_zero_bits: assert property (rise && rcnt_r inside {[5'h12:5'h16]} |-> !dat_q_r)
    else $error("padding bit not zero");
  a_gap_wait: assert property (fall && rcnt_r == 5'h18 |-> qcnt_r >= 12'h9C3)
    else $error("new frame inside the gap");
  a_gap_high: assert property (rcnt_r == 5'h18 && clk_q_r && ssi_clk |-> ssi_data)
    else $error("data line low between frames");

  c_frame_start: cover property (fall && rcnt_r == 5'h18);
  c_frame_end: cover property (rise && rcnt_r == 5'h17);
  c_fault_low: cover property (rise && rcnt_r == 5'h17 && !dat_q_r);
endmodule

// ==== sim/tb.sv ====
module tb
  import enc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************
  // stimulus, design and model state
  // ************************************
  logic        clock_in    = 1'b0;
  logic        rst_n_in    = 1'b0;
  logic        req_in      = 1'b0;
  logic        err_in      = 1'b0;
  logic        zero_set_in = 1'b0;
  enc_angle_t  angle_in    = 17'h00000;
  enc_angle_t  nv_zero_in  = 17'h00000;
  logic        nv_wr_out, a_out, a_n_out, b_out, b_n_out, idx_out, idx_n_out;
  logic        hall1_out, hall2_out, hall3_out, busy_out, valid_out, fault_out, frame_err_out;
  enc_angle_t  nv_data_out, angle_out;
  enc_angle_t  zero_m;     // zero the model expects in use
  enc_angle_t  p_m;
  enc_angle_t  exp_q[$];   // model: angles the pending frames must carry
  logic        ca_out, cb_out, cidx_out;
  logic [31:0] seed_r      = 32'h9E79;
  int          failures    = 0;
  int          samples_checked = 0;
  int          nv_pulses   = 0;

  always #4 clock_in = ~clock_in;

  // store pulses are one cycle long, so one look per cycle counts each once
  always @(negedge clock_in) if (nv_wr_out === 1'b1) nv_pulses++;

  enc_link_if link_i ();
  enc_link_if link_c_i ();
  // the coarse unit is only watched on its channels, so its link clock idles
  assign link_c_i.ssi_clk = 1'b1;
  enc_dev #(.COARSE(1'b1), .PRESET_HOLD_CYC(50)) enc_dev_c_i (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .angle_in(angle_in), .err_in(err_in), .zero_set_in(zero_set_in),
    .nv_zero_in(nv_zero_in), .nv_wr_out(), .nv_data_out(), .a_out(ca_out), .a_n_out(),
    .b_out(cb_out), .b_n_out(), .idx_out(cidx_out), .idx_n_out(), .hall1_out(),
    .hall2_out(), .hall3_out(), .link(link_c_i));
  enc_dev #(.PRESET_HOLD_CYC(50)) enc_dev_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .angle_in(angle_in), .err_in(err_in), .zero_set_in(zero_set_in), .nv_zero_in(nv_zero_in),
    .nv_wr_out(nv_wr_out), .nv_data_out(nv_data_out), .a_out(a_out), .a_n_out(a_n_out),
    .b_out(b_out), .b_n_out(b_n_out), .idx_out(idx_out), .idx_n_out(idx_n_out),
    .hall1_out(hall1_out), .hall2_out(hall2_out), .hall3_out(hall3_out), .link(link_i));
  enc_host enc_host_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .busy_out(busy_out), .valid_out(valid_out), .angle_out(angle_out), .fault_out(fault_out),
    .frame_err_out(frame_err_out), .link(link_i));
  enc_link_monitor enc_link_monitor_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .ssi_clk(link_i.ssi_clk), .ssi_data(link_i.ssi_data));

  // ************************************
  // helpers
  // ************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {16'h0000, exp}, {16'h0000, got});
  endtask

  // 0 waits for a decoded frame, 1 for the gap to end, 2 for a store pulse
  task automatic wait_for(input int sel, input int lim);
    for (int i = 0; i <= lim; i++) begin
      @(negedge clock_in);
      if (sel == 0 && valid_out === 1'b1) return;
      if (sel == 1 && busy_out === 1'b0) return;
      if (sel == 2 && nv_wr_out === 1'b1) return;
    end
    failures++;
    $display("ERROR wait %0d expected 1 seen 0", sel);
    print_verdict();
  endtask

  // angle must settle before the request since the device latches on the first fall
  task automatic frame(input enc_angle_t ang, input logic err);
    enc_angle_t rel;
    rel = ang - zero_m;
    angle_in = ang;
    err_in = err;
    repeat (5) @(negedge clock_in);
    chk_bit("a_out", rel[2] ^ rel[1], a_out);
    chk_bit("b_out", rel[2], b_out);
    chk_bit("idx_out", rel[16:1] == 16'h0000, idx_out);
    chk_word("pairs", 17'h00007,
      {14'h0000, a_out ^ a_n_out, b_out ^ b_n_out, idx_out ^ idx_n_out});
    chk_bit("hall1_out", {rel[14:0], 2'b00} < ENC_HALF_TURN, hall1_out);
    chk_bit("hall2_out", 17'({rel[14:0], 2'b00} - ENC_THIRD_TURN) < ENC_HALF_TURN,
      hall2_out);
    chk_bit("hall3_out", 17'({rel[14:0], 2'b00} - ENC_TWO_THIRDS) < ENC_HALF_TURN,
      hall3_out);
    chk_bit("a_out coarse", rel[4] ^ rel[3], ca_out);
    chk_bit("b_out coarse", rel[4], cb_out);
    chk_bit("idx_out coarse", rel[16:3] == 14'h0000, cidx_out);
    exp_q.push_back(rel);
    req_in = 1'b1;
    @(negedge clock_in);
    req_in = 1'b0;
    chk_bit("busy_out", 1'b1, busy_out);
    wait_for(0, 1300);
    chk_word("angle_out", exp_q.pop_front(), angle_out);
    chk_bit("fault_out", err, fault_out);
    chk_bit("frame_err_out", 1'b0, frame_err_out);
    wait_for(1, 2700);
  endtask

  task automatic do_reset(input enc_angle_t z);
    rst_n_in = 1'b0;
    nv_zero_in = z;
    zero_m = z;
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial begin
    seed_r = lfsr(seed_r);
    do_reset(seed_r[16:0]);
    // index position, one step past it, full scale, then random angles
    frame(zero_m, 1'b0);
    frame(zero_m + 17'h00001, 1'b1);
    frame(zero_m - 17'h00001, 1'b0);
    for (int k = 0; k < 4; k++) begin
      seed_r = lfsr(seed_r);
      frame(seed_r[16:0], seed_r[20]);
    end
    // a short press stores nothing
    zero_set_in = 1'b1;
    repeat (30) @(negedge clock_in);
    zero_set_in = 1'b0;
    repeat (10) @(negedge clock_in);
    chk_word("nv_pulses", 17'h00000, 17'(nv_pulses));
    // a full press stores the raw angle once, used only after power-up
    seed_r = lfsr(seed_r);
    p_m = seed_r[16:0];
    angle_in = p_m;
    zero_set_in = 1'b1;
    wait_for(2, 80);
    chk_word("nv_data_out", p_m, nv_data_out);
    repeat (100) @(negedge clock_in);
    zero_set_in = 1'b0;
    chk_word("nv_pulses", 17'h00001, 17'(nv_pulses));
    frame(p_m + 17'h00100, 1'b0);
    do_reset(p_m);
    frame(p_m, 1'b0);
    seed_r = lfsr(seed_r);
    frame(seed_r[16:0], 1'b1);
    print_verdict();
  end
endmodule

// ==== src/enc_dev.sv ====
module enc_dev
  import enc_pkg::*;
#(
  parameter bit          COARSE          = 1'b0,
  parameter int          POLE_PAIRS      = 4,
  parameter int unsigned PRESET_HOLD_CYC = ENC_PRESET_S * ENC_CLK_HZ
) (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire enc_angle_t angle_in,
  input  wire logic       err_in,
  input  wire logic       zero_set_in,
  input  wire enc_angle_t nv_zero_in,
  output logic            nv_wr_out,
  output enc_angle_t      nv_data_out,
  output logic            a_out,
  output logic            a_n_out,
  output logic            b_out,
  output logic            b_n_out,
  output logic            idx_out,
  output logic            idx_n_out,
  output logic            hall1_out,
  output logic            hall2_out,
  output logic            hall3_out,
  enc_link_if.device      link
);

  // ***********************************************************
  // zero position and relative angle
  // ***********************************************************
  logic       boot_r;
  enc_angle_t zero_r;
  enc_angle_t rel_r;
  enc_angle_t gray_r;
  logic       err_r;
  wire enc_angle_t rel_nxt = angle_in - zero_r;

  // zero is fetched once after reset; a later store is not seen until
  // the next power-up and the factory value is the EMF crossing
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_r <= 1'b0;
      zero_r <= ENC_ZERO_RST;
    end else if (!boot_r) begin
      boot_r <= 1'b1;
      zero_r <= nv_zero_in;
    end
  end

  // gray code lets the link sample the angle without a torn word
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_r  <= ENC_ZERO_RST;
      gray_r <= ENC_ZERO_RST;
      err_r  <= 1'b0;
    end else begin
      rel_r  <= rel_nxt;
      gray_r <= rel_r ^ (rel_r >> 1);
      err_r  <= err_in;
    end
  end

  // ***********************************************************
  // incremental channels
  // ***********************************************************
  wire [1:0] quad_ph  = COARSE ? rel_r[4:3] : rel_r[2:1];
  wire       at_zero  = COARSE ? (rel_r[16:3] == 14'h0000) : (rel_r[16:1] == 16'h0000);
  wire       front_nx = quad_ph[1] ^ quad_ph[0];  // rises first when counting up
  wire       follow_nx = quad_ph[1];

  // electrical angle for the commutation sensors
  wire enc_angle_t elec  = 17'(rel_r * POLE_PAIRS);
  wire enc_angle_t elec2 = elec - ENC_THIRD_TURN;
  wire enc_angle_t elec3 = elec - ENC_TWO_THIRDS;

  // every quadrature and index output and its complement come from their own flop; the hall outputs have no complement
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_out     <= 1'b0;
      a_n_out   <= 1'b1;
      b_out     <= 1'b0;
      b_n_out   <= 1'b1;
      idx_out   <= 1'b0;
      idx_n_out <= 1'b1;
      hall1_out <= 1'b0;
      hall2_out <= 1'b0;
      hall3_out <= 1'b0;
    end else begin
      a_out     <= front_nx;
      a_n_out   <= ~front_nx;
      b_out     <= follow_nx;
      b_n_out   <= ~follow_nx;
      idx_out   <= at_zero;
      idx_n_out <= ~at_zero;
      hall1_out <= elec < ENC_HALF_TURN;
      hall2_out <= elec2 < ENC_HALF_TURN;
      hall3_out <= elec3 < ENC_HALF_TURN;
    end
  end

  // ***********************************************************
  // zero set input
  // ***********************************************************
  logic        zs1_r;
  logic        zs2_r;
  logic        zs_done_r;
  logic [31:0] zs_cnt_r;
  wire         zs_fire = zs2_r && !zs_done_r && (zs_cnt_r == PRESET_HOLD_CYC - 1);

  // the pin must stay active for the whole hold time; one store per press
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zs1_r       <= 1'b0;
      zs2_r       <= 1'b0;
      zs_done_r   <= 1'b0;
      zs_cnt_r    <= 32'h00000000;
      nv_wr_out   <= 1'b0;
      nv_data_out <= ENC_ZERO_RST;
    end else begin
      zs1_r     <= zero_set_in;
      zs2_r     <= zs1_r;
      nv_wr_out <= zs_fire;
      if (!zs2_r) begin
        zs_cnt_r  <= 32'h00000000;
        zs_done_r <= 1'b0;
      end else if (zs_fire) begin
        zs_done_r   <= 1'b1;
        nv_data_out <= angle_in;
      end else if (!zs_done_r) begin
        zs_cnt_r <= zs_cnt_r + 32'h00000001;
      end
    end
  end

  // ***********************************************************
  // frame gap watch, local clock side
  // ***********************************************************
  localparam logic [11:0] ARM_AT = 12'(ENC_GAP_CYC - ENC_GAP_SLACK);

  logic        act_t_r;
  logic        done_r;
  logic        act1_r;
  logic        act2_r;
  logic        act3_r;
  logic        dn1_r;
  logic        dn2_r;
  logic [11:0] gap_r;
  logic        arm_n_r;
  wire         act_seen = act2_r ^ act3_r;

  // the link clock stops after a frame, so the gap is timed here and the
  // link logic is rearmed by a short reset while its clock stands still
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act1_r  <= 1'b0;
      act2_r  <= 1'b0;
      act3_r  <= 1'b0;
      dn1_r   <= 1'b0;
      dn2_r   <= 1'b0;
      gap_r   <= 12'h000;
      arm_n_r <= 1'b0;
    end else begin
      act1_r  <= act_t_r;
      act2_r  <= act1_r;
      act3_r  <= act2_r;
      dn1_r   <= done_r;
      dn2_r   <= dn1_r;
      arm_n_r <= !(dn2_r && gap_r == ARM_AT - 12'h001);
      if (act_seen) begin
        gap_r <= 12'h000;
      end else if (dn2_r && gap_r != ARM_AT) begin
        gap_r <= gap_r + 12'h001;
      end
    end
  end

  // ***********************************************************
  // serial frame, link clock side
  // ***********************************************************
  logic       started_r;
  enc_angle_t latch_r;
  logic       flt1_r;
  logic       flt2_r;
  logic [4:0] cnt_r;
  logic [20:0] shift_r;
  logic       data_r;
  enc_angle_t bin;

  // gray to binary, one xor reduction per bit
  for (genvar i = 0; i < ENC_POS_BITS; i++) begin : g_bin
    assign bin[i] = ^latch_r[ENC_POS_BITS-1:i];
  end

  assign link.ssi_data = data_r;

  // first falling edge of a frame takes the angle and the error level
  always_ff @(negedge link.ssi_clk or negedge arm_n_r) begin
    if (!arm_n_r) begin
      started_r <= 1'b0;
      latch_r   <= ENC_ZERO_RST;
      flt1_r    <= 1'b0;
    end else if (!started_r) begin
      started_r <= 1'b1;
      latch_r   <= gray_r;
      flt1_r    <= err_r;
    end
  end

  // one bit per rising edge; fast enough for any clock up to the limit
  // since all bit work sits in a single edge-to-edge step
  always_ff @(posedge link.ssi_clk or negedge arm_n_r) begin
    if (!arm_n_r) begin
      act_t_r <= 1'b0;
      done_r  <= 1'b0;
      flt2_r  <= 1'b0;
      cnt_r   <= 5'h00;
      shift_r <= 21'h000000;
      data_r  <= 1'b1;
    end else begin
      act_t_r <= ~act_t_r;
      flt2_r  <= flt1_r;
      if (started_r && !done_r) begin
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == 5'h00) begin
          data_r  <= bin[ENC_POS_BITS-1];
          shift_r <= {bin[ENC_POS_BITS-2:0], 5'h00};
        end else if (cnt_r == ENC_LAST_CNT) begin
          data_r <= ~flt2_r;
        end else if (cnt_r == ENC_END_CNT) begin
          data_r <= 1'b1;
          done_r <= 1'b1;
        end else begin
          data_r  <= shift_r[20];
          shift_r <= {shift_r[19:0], 1'b0};
        end
      end
    end
  end

endmodule

// ==== src/enc_host.sv ====
module enc_host
  import enc_pkg::*;
(
  input  wire logic  clock_in,
  input  wire logic  rst_n_in,
  input  wire logic  req_in,
  output logic       busy_out,
  output logic       valid_out,
  output enc_angle_t angle_out,
  output logic       fault_out,
  output logic       frame_err_out,
  enc_link_if.host   link
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RUN  = 3'b010,
    HS_GAP  = 3'b100
  } enc_hst_e;

  localparam logic [5:0]  HALF_LAST = 6'(ENC_HALF_CYC - 1);
  localparam logic [11:0] GAP_LAST  = 12'(ENC_GAP_CYC - 1);

  // ***********************************************************
  // clock divider and frame sequencer
  // ***********************************************************
  enc_hst_e    st_r;
  logic [5:0]  hc_r;
  logic [4:0]  rise_r;
  logic [11:0] gap_r;
  logic        sclk_r;
  logic        d1_r;
  logic        d2_r;
  logic [21:0] shift_r;

  wire         half_end = (hc_r == HALF_LAST);
  wire         rising   = half_end && !sclk_r;
  wire [22:0]  frame    = {shift_r, d2_r};
  // the fault bit is shown after rise 23, so it is taken as rise 24 is made
  wire         last     = rising && (rise_r == ENC_END_CNT);

  assign link.ssi_clk = sclk_r;

  // data pin passes two flops; bit k is taken as rising edge k+1 is made
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r          <= HS_IDLE;
      hc_r          <= 6'h00;
      rise_r        <= 5'h00;
      gap_r         <= 12'h000;
      sclk_r        <= 1'b1;
      d1_r          <= 1'b1;
      d2_r          <= 1'b1;
      shift_r       <= 22'h000000;
      busy_out      <= 1'b0;
      valid_out     <= 1'b0;
      angle_out     <= ENC_ZERO_RST;
      fault_out     <= 1'b0;
      frame_err_out <= 1'b0;
    end else begin
      d1_r      <= link.ssi_data;
      d2_r      <= d1_r;
      valid_out <= last;
      case (st_r)
        HS_IDLE: begin
          if (req_in) begin
            st_r     <= HS_RUN;
            sclk_r   <= 1'b0;
            hc_r     <= 6'h00;
            rise_r   <= 5'h00;
            busy_out <= 1'b1;
          end
        end
        HS_RUN: begin
          hc_r <= half_end ? 6'h00 : hc_r + 6'h01;
          if (half_end) begin
            sclk_r <= ~sclk_r;
          end
          if (rising) begin
            rise_r <= rise_r + 5'h01;
            if (rise_r != 5'h00) begin
              shift_r <= {shift_r[20:0], d2_r};
            end
          end
          if (last) begin
            st_r          <= HS_GAP;
            gap_r         <= 12'h000;
            angle_out     <= 17'((frame & ENC_POS_MASK) >> ENC_ANGLE_LSB);
            fault_out     <= ~frame[ENC_FAULT_BIT];
            frame_err_out <= |frame[ENC_ZERO_BITS:1];
          end
        end
        HS_GAP: begin
          gap_r <= gap_r + 12'h001;
          if (gap_r == GAP_LAST) begin
            st_r     <= HS_IDLE;
            busy_out <= 1'b0;
          end
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== src/enc_link_if.sv ====
// serial link between the encoder and the motor controller
interface enc_link_if;
  logic ssi_clk;   // made by the controller, idles high
  logic ssi_data;  // driven by the encoder

  modport device (input ssi_clk, output ssi_data);
  modport host   (output ssi_clk, input ssi_data);
endinterface

// ==== src/enc_pkg.sv ====
// Summary of operation
// - serial clock at most 4 MHz, frames stay correct
// - every serial frame holds exactly 23 bits
// - first falling edge latches position, start bit one
// - 17 angle bits MSB first on rising edges
// - five zero bits follow the angle bits
// - last bit fault flag, zero means error
// - controller waits 20 us between frames
// - receiver maps angle bits 22..6, fault bit 0
// - receiver treats fault flag one as healthy
// - factory zero sits at back EMF crossing
// - clockwise rotation, front leads follow by 90
// - index 90 degrees wide, on follow edge
// - every incremental output has inverted twin
// - commutation sensor 1 edges at EMF crossings
// - 131072 serial positions, 16384/4096 incremental counts
// - zero set stores shaft position nonvolatile
// - operator holds zero set at least 3 s
// - new zero used only after power cycle
package enc_pkg;

  // ***********************************************************
  // clock and link timing
  // ***********************************************************
  localparam int ENC_CLK_HZ      = 125_000_000;
  localparam int ENC_SCLK_MAX_HZ = 4_000_000;
  localparam int ENC_SCLK_REC_HZ = 2_625_000;
  // half period of the made serial clock, rounded up so the rate stays low
  localparam int ENC_HALF_CYC    = (ENC_CLK_HZ + 2 * ENC_SCLK_REC_HZ - 1) / (2 * ENC_SCLK_REC_HZ);
  localparam int ENC_GAP_US      = 20;
  localparam int ENC_GAP_CYC     = (ENC_GAP_US * (ENC_CLK_HZ / 1_000_000));
  // device rearms this much early to cover its synchroniser delay
  localparam int ENC_GAP_SLACK   = 8;
  localparam int ENC_PRESET_S    = 3;

  // ***********************************************************
  // frame layout
  // ***********************************************************
  localparam int          ENC_FRAME_BITS = 23;
  localparam int          ENC_POS_BITS   = 17;
  localparam int          ENC_ZERO_BITS  = 5;
  localparam int          ENC_FAULT_BIT  = 0;
  localparam int          ENC_ANGLE_LSB  = 6;
  localparam logic [22:0] ENC_POS_MASK   = 23'h7FFFC0;
  localparam logic [4:0]  ENC_LAST_CNT   = 5'h16;
  localparam logic [4:0]  ENC_END_CNT    = 5'h17;

  // ***********************************************************
  // incremental and commutation geometry
  // ***********************************************************
  localparam logic [16:0] ENC_HALF_TURN  = 17'h10000;
  localparam logic [16:0] ENC_THIRD_TURN = 17'h0AAAB;
  localparam logic [16:0] ENC_TWO_THIRDS = 17'h15555;
  localparam logic [16:0] ENC_ZERO_RST   = 17'h00000;

  typedef logic [16:0] enc_angle_t;

endpackage
